/* File: rtl/power_ctrl_pkg.sv */
// constants shared by the power mode and command control block
package power_ctrl_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 250; // system clock rate
	localparam int HOLD_NS = 10000; // hard-off level that resets
	localparam int BOOT_NS = 15000; // start-up after standby
	localparam int READY_US = 2500; // start-up after hard reset
	// least times round up to whole cycles
	localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int BOOT_CYC = (BOOT_NS * CLK_MHZ + 999) / 1000;
	localparam int READY_CYC = READY_US * CLK_MHZ;

	// ----------------------------------------------------------------
	// command register layout and command codes
	// ----------------------------------------------------------------
	localparam int STANDBY_BIT = 7; // standby_request_bit position
	localparam int CODE_MSB = 4; // command code in bits 4..0
	typedef logic [4:0] code_type;
	localparam code_type CMD_IDLE = 5'h00;
	localparam code_type CMD_TAG_DETECT = 5'h01;
	localparam code_type CMD_QUERY_ACK = 5'h04;
	localparam code_type CMD_RECEIVE = 5'h05;
	localparam code_type CMD_TRANSMIT = 5'h06;
	localparam code_type CMD_TRANSCEIVE = 5'h07;
	localparam code_type CMD_EE_BYTE = 5'h08;
	localparam code_type CMD_EE_PAGE = 5'h09;
	localparam code_type CMD_EE_READ = 5'h0A;
	localparam code_type CMD_EE_TO_REG = 5'h0C;
	localparam code_type CMD_PROTOCOL = 5'h0D;
	localparam code_type CMD_RANDOM = 5'h1C;
	localparam code_type CMD_SOFT_RESET = 5'h1F;

	// ----------------------------------------------------------------
	// eeprom sector check for the register copy command
	// ----------------------------------------------------------------
	localparam int SECTOR_SHIFT = 7; // sector size 128 bytes
	localparam logic [8:0] COPY_SECTOR = 9'h002;

	// controller states, one-hot
	typedef enum logic [7:0] {
		ST_OFF = 8'h01,
		ST_BOOT = 8'h02,
		ST_IDLE = 8'h04,
		ST_FETCH = 8'h08,
		ST_RUN = 8'h10,
		ST_STANDBY = 8'h20,
		ST_WAKE_WAIT = 8'h40,
		ST_SAMPLE = 8'h80
	} state_type;

endpackage

/* File: rtl/power_mode_and_command_control.sv */
// power modes, start-up sequencing and command dispatch of the front end
`timescale 1ns/1ps
module power_mode_and_command_control
	import power_ctrl_pkg::*;
#(
	parameter int READY_CYCLES = power_ctrl_pkg::READY_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic hard_off_pin,
	input wire logic cmd_wr,
	input wire logic [7:0] cmd_data,
	input wire logic wake_byte_seen,
	input wire logic front_end_off_bit,
	input wire logic [9:0] fifo_count,
	input wire logic [7:0] fifo_rdata,
	input wire logic exec_done,
	input wire logic slow_tick,
	input wire logic [15:0] wakeup_counter,
	input wire logic wake_timer_auto_wake,
	input wire logic wake_timer_auto_reload,
	input wire logic sample_valid,
	input wire logic [7:0] adc_i,
	input wire logic [7:0] adc_q,
	input wire logic [7:0] i_lower_limit,
	input wire logic [7:0] i_upper_limit,
	input wire logic [7:0] q_lower_limit,
	input wire logic [7:0] q_upper_limit,
	output logic pads_hiz,
	output logic inputs_clamped,
	output logic regs_reset,
	output logic fifo_clear,
	output logic fifo_pop,
	output logic ready,
	output logic standby_active,
	output logic front_end_on,
	output logic exec_start,
	output logic exec_abort,
	output logic cmd_error,
	output logic soft_reset,
	output logic [4:0] exec_code,
	output logic [31:0] exec_args,
	output logic tag_detect_irq,
	output logic [7:0] i_channel_sample,
	output logic [7:0] q_channel_sample,
	output logic [15:0] slow_period
);
	import power_ctrl_pkg::*;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// argument bytes of a command; it starts once args_popped of them are taken
	function automatic logic [2:0] args_needed(input code_type c);
		unique case (c)
			CMD_EE_BYTE, CMD_EE_READ: args_needed = 3'd3;
			CMD_EE_PAGE, CMD_PROTOCOL: args_needed = 3'd2;
			CMD_EE_TO_REG: args_needed = 3'd4;
			default: args_needed = 3'd0;
		endcase
	endfunction

	// argument bytes taken out; page data stays for the eeprom engine
	function automatic logic [2:0] args_popped(input code_type c);
		args_popped = (c == CMD_EE_PAGE) ? 3'd1 : args_needed(c);
	endfunction

	// true when a sample lies outside its window
	function automatic logic outside(input logic [7:0] v,
		input logic [7:0] lo, input logic [7:0] hi);
		outside = (v < lo) || (v > hi);
	endfunction

	// ----------------------------------------------------------------
	// controller state
	// ----------------------------------------------------------------
	state_type state_reg, state_next; // controller state
	logic [19:0] boot_cnt_reg, boot_cnt_next; // start-up countdown
	logic [11:0] hold_cnt_reg, hold_cnt_next; // hard-off level length
	logic [15:0] wake_cnt_reg, wake_cnt_next; // slow ticks in standby
	logic [2:0] argc_reg, argc_next; // argument bytes taken
	code_type code_reg, code_next; // current command
	logic [31:0] args_reg, args_next; // arguments, each new byte shifted in at the high byte
	logic [7:0] isamp_reg, isamp_next;
	logic [7:0] qsamp_reg, qsamp_next;
	logic irq_reg, irq_next;
	logic start_reg, start_next;
	logic abort_reg, abort_next;
	logic err_reg, err_next;
	logic srst_reg, srst_next;
	logic wipe_reg, wipe_next; // internal reset pulse
	logic busy; // a command owns the datapath
	logic tag_seen; // sample outside the window
	logic [8:0] copy_sector; // sector of register copy address

	assign busy = (state_reg == ST_FETCH) || (state_reg == ST_RUN) ||
		(state_reg == ST_WAKE_WAIT) || (state_reg == ST_SAMPLE);
	assign tag_seen = outside(adc_i, i_lower_limit, i_upper_limit) ||
		outside(adc_q, q_lower_limit, q_upper_limit);
	assign copy_sector = {1'b0, args_reg[7:0]} << (8 - SECTOR_SHIFT) |
		9'(args_reg[15:8] >> SECTOR_SHIFT);

	// next state of the controller
	always_comb begin
		state_next = state_reg;
		boot_cnt_next = boot_cnt_reg;
		hold_cnt_next = hold_cnt_reg;
		wake_cnt_next = wake_cnt_reg;
		argc_next = argc_reg;
		code_next = code_reg;
		args_next = args_reg;
		isamp_next = isamp_reg;
		qsamp_next = qsamp_reg;
		irq_next = 1'b0;
		start_next = 1'b0;
		abort_next = 1'b0;
		err_next = 1'b0;
		srst_next = 1'b0;
		wipe_next = 1'b0;
		fifo_pop = 1'b0;
		if (hard_off_pin) begin
			// pin wins over everything; time the level
			state_next = ST_OFF;
			if (hold_cnt_reg != 12'(HOLD_CYC)) begin
				hold_cnt_next = hold_cnt_reg + 12'h001;
			end
			if (hold_cnt_reg == 12'(HOLD_CYC - 1)) begin
				// internal reset: registers back to defaults
				wipe_next = 1'b1;
				boot_cnt_next = 20'(BOOT_CYC);
				wake_cnt_next = 16'h0000;
				argc_next = 3'd0;
				code_next = CMD_IDLE;
				args_next = 32'h0000_0000;
				isamp_next = 8'h00;
				qsamp_next = 8'h00;
			end
		end else begin
			unique case (state_reg)
				ST_OFF: begin
					// a short glitch does not reset, so resume quickly
					state_next = ST_BOOT;
					boot_cnt_next = (hold_cnt_reg == 12'(HOLD_CYC)) ?
						20'(READY_CYCLES) : 20'(BOOT_CYC);
					hold_cnt_next = 12'h000;
					code_next = CMD_IDLE;
				end
				ST_BOOT: begin
					if (boot_cnt_reg <= 20'h00001) begin
						state_next = ST_IDLE;
					end else begin
						boot_cnt_next = boot_cnt_reg - 20'h00001;
					end
				end
				ST_STANDBY: begin
					// everything held; only a wake starts start-up
					if ((cmd_wr && !cmd_data[STANDBY_BIT]) ||
						wake_byte_seen) begin
						state_next = ST_BOOT;
						boot_cnt_next = 20'(BOOT_CYC);
					end
				end
				ST_FETCH: begin
					// fifo is not cleared: arguments come from it
					if (argc_reg == args_popped(code_reg)) begin
						state_next = ST_RUN;
						start_next = 1'b1;
						if (code_reg == CMD_EE_TO_REG &&
							copy_sector != COPY_SECTOR) begin
							state_next = ST_IDLE;
							start_next = 1'b0;
							err_next = 1'b1;
						end
					end else if (fifo_count != 10'h000) begin
						fifo_pop = 1'b1;
						args_next = {fifo_rdata, args_reg[31:8]};
						argc_next = argc_reg + 3'd1;
					end
				end
				ST_RUN: begin
					if (exec_done) begin
						state_next = ST_IDLE;
					end
				end
				ST_WAKE_WAIT: begin
					// standby phase measured in slow oscillator ticks
					if (wake_cnt_reg >= wakeup_counter) begin
						state_next = ST_SAMPLE;
					end else if (slow_tick) begin
						wake_cnt_next = wake_cnt_reg + 16'h0001;
					end
				end
				ST_SAMPLE: begin
					if (sample_valid) begin
						isamp_next = adc_i;
						qsamp_next = adc_q;
						irq_next = tag_seen;
						wake_cnt_next = 16'h0000;
						if (tag_seen || !wake_timer_auto_wake) begin
							state_next = ST_IDLE;
						end else if (wake_timer_auto_reload) begin
							state_next = ST_WAKE_WAIT;
						end else begin
							state_next = ST_STANDBY;
						end
					end
				end
				default: begin
				end
			endcase
			// command writes: standby bit, then abort and dispatch
			if (cmd_wr && state_reg != ST_OFF && state_reg != ST_BOOT &&
				state_reg != ST_STANDBY) begin
				abort_next = busy;
				// a new code cancels a start, error or pop of the old one
				start_next = 1'b0;
				err_next = 1'b0;
				fifo_pop = 1'b0;
				code_next = cmd_data[CODE_MSB:0];
				argc_next = 3'd0;
				args_next = 32'h0000_0000;
				wake_cnt_next = 16'h0000;
				state_next = ST_IDLE;
				if (cmd_data[STANDBY_BIT]) begin
					state_next = ST_STANDBY;
				end else if (cmd_data[CODE_MSB:0] == CMD_SOFT_RESET) begin
					srst_next = 1'b1;
				end else if (cmd_data[CODE_MSB:0] == CMD_TAG_DETECT) begin
					state_next = ST_WAKE_WAIT;
				end else if (cmd_data[CODE_MSB:0] != CMD_IDLE) begin
					state_next = ST_FETCH;
				end
			end
		end
	end

	// controller registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_reg <= ST_BOOT;
			boot_cnt_reg <= 20'(BOOT_CYC);
			hold_cnt_reg <= 12'h000;
			wake_cnt_reg <= 16'h0000;
			argc_reg <= 3'd0;
			code_reg <= CMD_IDLE;
			args_reg <= 32'h0000_0000;
			isamp_reg <= 8'h00;
			qsamp_reg <= 8'h00;
			irq_reg <= 1'b0;
			start_reg <= 1'b0;
			abort_reg <= 1'b0;
			err_reg <= 1'b0;
			srst_reg <= 1'b0;
			wipe_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			boot_cnt_reg <= boot_cnt_next;
			hold_cnt_reg <= hold_cnt_next;
			wake_cnt_reg <= wake_cnt_next;
			argc_reg <= argc_next;
			code_reg <= code_next;
			args_reg <= args_next;
			isamp_reg <= isamp_next;
			qsamp_reg <= qsamp_next;
			irq_reg <= irq_next;
			start_reg <= start_next;
			abort_reg <= abort_next;
			err_reg <= err_next;
			srst_reg <= srst_next;
			wipe_reg <= wipe_next;
		end
	end

	// ----------------------------------------------------------------
	// slow oscillator period measurement
	// ----------------------------------------------------------------
	logic [15:0] tcnt_reg, tcnt_next; // clocks since last tick
	logic [15:0] period_reg, period_next; // last full period

	// count system clocks between slow ticks; saturates if stopped
	always_comb begin
		tcnt_next = (tcnt_reg == 16'hFFFF) ? tcnt_reg : tcnt_reg + 16'h0001;
		period_next = period_reg;
		if (slow_tick) begin
			period_next = tcnt_reg;
			tcnt_next = 16'h0001;
		end
	end

	// measurement registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tcnt_reg <= 16'h0000;
			period_reg <= 16'h0000;
		end else begin
			tcnt_reg <= tcnt_next;
			period_reg <= period_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign pads_hiz = hard_off_pin;
	assign inputs_clamped = hard_off_pin;
	assign regs_reset = wipe_reg;
	assign fifo_clear = wipe_reg;
	assign ready = (state_reg == ST_IDLE) || (state_reg == ST_FETCH) ||
		(state_reg == ST_RUN);
	assign standby_active = (state_reg == ST_STANDBY) ||
		(state_reg == ST_WAKE_WAIT);
	// the front end needs full power and a cleared off bit
	assign front_end_on = ready && !front_end_off_bit;
	assign exec_start = start_reg;
	assign exec_abort = abort_reg;
	assign cmd_error = err_reg;
	assign soft_reset = srst_reg;
	assign exec_code = code_reg;
	assign exec_args = args_reg;
	assign tag_detect_irq = irq_reg;
	assign i_channel_sample = isamp_reg;
	assign q_channel_sample = qsamp_reg;
	assign slow_period = period_reg;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	// pads float at once; the state drops to off one edge later
	a_hard_off_float: assert property (
		hard_off_pin |-> pads_hiz && inputs_clamped ##1
		!ready && !front_end_on) else $error("pins not floated");
	a_reset_hold: assert property ($rose(regs_reset) |->
		hold_cnt_reg == 12'(HOLD_CYC)) else $error("early reset");
	a_standby_enter: assert property (
		cmd_wr && cmd_data[STANDBY_BIT] && ready && !hard_off_pin |=>
		standby_active && !front_end_on)
		else $error("standby not entered");
	a_standby_exit: assert property (state_reg == ST_STANDBY &&
		cmd_wr && !cmd_data[STANDBY_BIT] && !hard_off_pin |=>
		state_reg == ST_BOOT ##1 !ready [*8])
		else $error("bad standby exit");
	a_front_end_off: assert property (
		front_end_off_bit |-> !front_end_on) else $error("front end on");
	a_arg_wait: assert property (state_reg == ST_FETCH &&
		fifo_count == 10'h000 |-> !fifo_pop && !exec_start)
		else $error("popped empty fifo");
	a_abort_run: assert property (cmd_wr && state_reg == ST_RUN &&
		!hard_off_pin && !cmd_data[STANDBY_BIT] |=> exec_abort)
		else $error("no abort");
	a_irq_cause: assert property (state_reg == ST_SAMPLE &&
		sample_valid && !hard_off_pin && !cmd_wr |=>
		tag_detect_irq == $past(tag_seen)) else $error("irq mismatch");
	a_no_standby: assert property (state_reg == ST_SAMPLE &&
		sample_valid && !tag_seen && !wake_timer_auto_wake &&
		!hard_off_pin && !cmd_wr |=> state_reg == ST_IDLE)
		else $error("entered standby");

	c_tag_found: cover property (tag_detect_irq);
	c_standby_cycle: cover property (state_reg == ST_STANDBY ##[1:50]
		state_reg == ST_BOOT);
	c_cmd_run: cover property (exec_start ##[1:50] exec_abort);

endmodule

/* File: test/fifo_host_model.sv */
// host side stand-in: argument fifo and command engine completion
`timescale 1ns/1ps
module fifo_host_model (
	input wire logic clk_sys,
	input wire logic fifo_pop,
	input wire logic fifo_clear,
	input wire logic exec_start,
	input wire logic exec_abort,
	output logic [9:0] fifo_count,
	output logic [7:0] fifo_rdata,
	output logic exec_done
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [7:0] q[$]; // bytes waiting, head first
	logic [7:0] last; // last byte popped
	int done_delay; // engine run time in cycles
	int left; // cycles until done
	initial begin
		last = 8'h00;
		done_delay = 4;
		left = 0;
		fifo_count = 10'h000;
		fifo_rdata = 8'hFF;
		exec_done = 1'b0;
	end
	// host loads arguments ahead of the command code
	task push(input logic [7:0] b);
		q.push_back(b);
		fifo_count = 10'(q.size());
		fifo_rdata = q[0];
	endtask
	// host empties the fifo between scenarios
	task flush;
		q.delete();
		fifo_count = 10'h000;
		fifo_rdata = ~last;
	endtask
	// pops, wipes and engine completion, all on the rising edge
	always @(posedge clk_sys) begin
		if (fifo_clear === 1'b1) begin
			q.delete();
		end else if (fifo_pop === 1'b1 && q.size() > 0) begin
			last = q.pop_front();
		end
		fifo_count <= 10'(q.size());
		// an empty fifo shows no stale head byte
		fifo_rdata <= (q.size() > 0) ? q[0] : ~last;
		exec_done <= 1'b0;
		if (exec_abort === 1'b1) begin
			left = 0;
		end else if (exec_start === 1'b1) begin
			left = done_delay;
		end else if (left > 0) begin
			left = left - 1;
			exec_done <= (left == 0);
		end
	end
endmodule

/* File: test/tb.sv */
// self-checking bench for the power mode and command control block
`timescale 1ns/1ps
module tb;
	import power_ctrl_pkg::*;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	localparam int RDY = 20; // shortened hard-reset start-up
	logic clk_sys, rst, hard_off_pin, cmd_wr, wake_byte_seen;
	logic front_end_off_bit, exec_done, slow_tick, sample_valid;
	logic wake_timer_auto_wake, wake_timer_auto_reload;
	logic [7:0] cmd_data, fifo_rdata, adc_i, adc_q;
	logic [7:0] i_lower_limit, i_upper_limit, q_lower_limit, q_upper_limit;
	logic [9:0] fifo_count;
	logic [15:0] wakeup_counter, slow_period;
	logic pads_hiz, inputs_clamped, regs_reset, fifo_clear, fifo_pop;
	logic ready, standby_active, front_end_on, exec_start, exec_abort;
	logic cmd_error, soft_reset, tag_detect_irq;
	logic [4:0] exec_code;
	logic [31:0] exec_args;
	logic [7:0] i_channel_sample, q_channel_sample;
	int err_count = 0, cmp_count = 0, div = 0;
	int n_st = 0, n_ab = 0, n_er = 0, n_sr = 0, n_irq = 0, n_rr = 0;
	code_type codes[11] = '{CMD_IDLE, CMD_QUERY_ACK, CMD_RECEIVE,
		CMD_TRANSMIT, CMD_TRANSCEIVE, CMD_EE_BYTE, CMD_EE_PAGE, CMD_EE_READ,
		CMD_EE_TO_REG, CMD_PROTOCOL, CMD_RANDOM};
	// window limits stay fixed; samples move around them
	assign i_lower_limit = 8'h40;
	assign i_upper_limit = 8'hC0;
	assign q_lower_limit = 8'h40;
	assign q_upper_limit = 8'hC0;

	power_mode_and_command_control #(.READY_CYCLES(RDY)) DUT (
		.clk_sys(clk_sys), .rst(rst), .hard_off_pin(hard_off_pin),
		.cmd_wr(cmd_wr), .cmd_data(cmd_data),
		.wake_byte_seen(wake_byte_seen),
		.front_end_off_bit(front_end_off_bit), .fifo_count(fifo_count),
		.fifo_rdata(fifo_rdata), .exec_done(exec_done),
		.slow_tick(slow_tick), .wakeup_counter(wakeup_counter),
		.wake_timer_auto_wake(wake_timer_auto_wake),
		.wake_timer_auto_reload(wake_timer_auto_reload),
		.sample_valid(sample_valid), .adc_i(adc_i), .adc_q(adc_q),
		.i_lower_limit(i_lower_limit), .i_upper_limit(i_upper_limit),
		.q_lower_limit(q_lower_limit), .q_upper_limit(q_upper_limit),
		.pads_hiz(pads_hiz), .inputs_clamped(inputs_clamped),
		.regs_reset(regs_reset), .fifo_clear(fifo_clear),
		.fifo_pop(fifo_pop), .ready(ready),
		.standby_active(standby_active), .front_end_on(front_end_on),
		.exec_start(exec_start), .exec_abort(exec_abort),
		.cmd_error(cmd_error), .soft_reset(soft_reset),
		.exec_code(exec_code), .exec_args(exec_args),
		.tag_detect_irq(tag_detect_irq),
		.i_channel_sample(i_channel_sample),
		.q_channel_sample(q_channel_sample),
		.slow_period(slow_period));
	fifo_host_model hostm (.clk_sys(clk_sys), .fifo_pop(fifo_pop),
		.fifo_clear(fifo_clear), .exec_start(exec_start),
		.exec_abort(exec_abort), .fifo_count(fifo_count),
		.fifo_rdata(fifo_rdata), .exec_done(exec_done));

	// ----------------------------------------------------------------
	// clock, slow tick and pulse counters
	// ----------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	// slow oscillator stand-in: one tick every ten clocks
	always @(posedge clk_sys) begin
		div <= (div == 9) ? 0 : div + 1;
		slow_tick <= #1 (div == 9);
	end
	// pulses counted on the falling edge, well clear of updates
	always @(negedge clk_sys) begin
		n_st += (exec_start === 1'b1);
		n_ab += (exec_abort === 1'b1);
		n_er += (cmd_error === 1'b1);
		n_sr += (soft_reset === 1'b1);
		n_irq += (tag_detect_irq === 1'b1);
		n_rr += (regs_reset === 1'b1 && fifo_clear === 1'b1);
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task stop_test;
		$display("errors %0d compares %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task cmd(input logic [7:0] b);
		cmd_data = b;
		cmd_wr = 1'b1;
		step(1);
		cmd_wr = 1'b0;
	endtask
	function logic pick(input int s);
		case (s)
			0: return ready;
			1: return exec_start;
			default: return !standby_active;
		endcase
	endfunction
	// bounded wait; running out ends the run as a failure
	task wait_on(input int s, input int n, output int c);
		c = 0;
		while (pick(s) !== 1'b1 && c < n) begin
			step(1);
			c++;
		end
		if (pick(s) !== 1'b1) begin
			err_count++;
			$display("Error wait %0d expected 1 seen 0", s);
			stop_test();
		end
	endtask
	initial begin
		repeat (80000) @(posedge clk_sys);
		err_count++;
		$display("Error watchdog expected finish seen hang");
		stop_test();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		int c, k, e, x;
		logic [7:0] a[4];
		logic [31:0] ea;
		void'($urandom(10456));
		rst = 1'b1;
		hard_off_pin = 1'b0;
		cmd_wr = 1'b0;
		cmd_data = 8'h00;
		wake_byte_seen = 1'b0;
		front_end_off_bit = 1'b0;
		wake_timer_auto_reload = 1'b0;
		wakeup_counter = 16'h0003;
		wake_timer_auto_wake = 1'b0;
		sample_valid = 1'b0;
		adc_i = 8'h00;
		adc_q = 8'h00;
		repeat (6) @(posedge clk_sys);
		#1 rst = 1'b0;
		wait_on(0, BOOT_CYC + 10, c);
		chk("boot", c >= BOOT_CYC - 3 && c <= BOOT_CYC + 2, 1);
		// byte write: arguments collected in fifo order
		for (k = 0; k < 3; k++) begin
			a[k] = 8'($urandom);
			hostm.push(a[k]);
		end
		cmd({3'h0, CMD_EE_BYTE});
		wait_on(1, 20, c);
		chk("args", exec_args[31:8], {a[2], a[1], a[0]});
		chk("fifo kept", n_rr, 0);
		step(8);
		// starved preset load must not start, then abort it
		hostm.flush();
		hostm.push(8'h01);
		e = n_st;
		cmd({3'h0, CMD_PROTOCOL});
		step(20);
		chk("early start", n_st, e);
		hostm.done_delay = 200;
		hostm.push(8'h02);
		wait_on(1, 20, c);
		e = n_ab;
		cmd(8'h00);
		step(2);
		chk("abort", n_ab - e, 1);
		hostm.done_delay = 4;
		// register copy: sector boundaries then random addresses
		for (k = 0; k < 6; k++) begin
			hostm.flush();
			a[0] = (k < 2) ? 8'h01 : (k == 2) ? 8'h00 : 8'($urandom % 2);
			a[1] = (k == 0) ? 8'h7F : (k < 3) ? 8'hFF : 8'($urandom);
			for (x = 0; x < 4; x++)
				hostm.push((x < 2) ? a[x] : 8'h01);
			e = n_er;
			cmd({3'h0, CMD_EE_TO_REG});
			step(12);
			x = !(a[0] == 8'h01 && a[1] < 8'h80);
			chk("sector", n_er - e, x);
			cmd(8'h00);
			step(2);
		end
		// every code that needs no sampling, soft reset after
		for (k = 0; k < 12; k++) begin
			hostm.flush();
			for (x = 0; x < 4; x++)
				hostm.push(8'($urandom));
			e = n_sr;
			cmd({3'h0, (k < 11) ? codes[k] : CMD_SOFT_RESET});
			step(1);
			if (k < 11)
				chk("code", exec_code, codes[k]);
			step(10);
			chk("soft reset", n_sr - e, k == 11);
			cmd(8'h00);
			wait_on(0, BOOT_CYC + 10, c);
		end
		// standby keeps state; clear bit, then wake byte
		ea = exec_args;
		cmd(8'h80);
		chk("standby", {standby_active, ready}, 2'b10);
		step(30);
		chk("args kept", exec_args, ea);
		chk("pads", pads_hiz, 0);
		cmd(8'h00);
		wait_on(0, BOOT_CYC + 10, c);
		chk("wake", c >= BOOT_CYC - 3 && c <= BOOT_CYC + 2, 1);
		cmd(8'h80);
		wake_byte_seen = 1'b1;
		step(1);
		wake_byte_seen = 1'b0;
		wait_on(0, BOOT_CYC + 10, c);
		chk("wake byte", standby_active, 0);
		for (k = 0; k < 2; k++) begin
			front_end_off_bit = k[0];
			step(1);
			chk("front end", front_end_on, !k[0]);
		end
		// tag detection: auto wake off, then auto wake, then reload
		for (k = 0; k < 5; k++) begin
			wake_timer_auto_wake = (k > 2);
			wake_timer_auto_reload = (k == 4);
			cmd({3'h0, CMD_TAG_DETECT});
			chk("wake phase", standby_active, 1);
			wait_on(2, 100, c);
			chk("wake count", c >= 20, 1);
			chk("slow period", slow_period, 10);
			a[0] = (k == 0) ? 8'hF0 : (k > 2) ? 8'h80 : 8'($urandom);
			a[1] = (k > 2) ? 8'h80 : 8'($urandom);
			adc_i = a[0];
			adc_q = a[1];
			sample_valid = 1'b1;
			e = n_irq;
			step(1);
			sample_valid = 1'b0;
			step(2);
			x = a[0] < 8'h40 || a[0] > 8'hC0 || a[1] < 8'h40 || a[1] > 8'hC0;
			chk("irq", n_irq - e, x);
			chk("samples", {i_channel_sample, q_channel_sample}, {a[0], a[1]});
			chk("awake", ready, k < 3);
			chk("rearm", standby_active, k > 2);
			if (k > 2) begin
				cmd(8'h00);
				wait_on(0, BOOT_CYC + 10, c);
			end
		end
		// short hard-off floats only; long one wipes
		e = n_rr;
		hard_off_pin = 1'b1;
		#1 chk("float", {pads_hiz, inputs_clamped}, 2'b11);
		step(100);
		hard_off_pin = 1'b0;
		step(2);
		chk("glitch", n_rr, e);
		wait_on(0, BOOT_CYC + 10, c);
		hostm.push(8'h11);
		hard_off_pin = 1'b1;
		step(HOLD_CYC + 20);
		chk("wipe", n_rr - e, 1);
		chk("fifo", fifo_count, 0);
		hard_off_pin = 1'b0;
		wait_on(0, RDY + 10, c);
		chk("code wiped", exec_code, 0);
		stop_test();
	end
endmodule
